/* hdl/motol_trip.sv */
// Thermal overload supervision with trip classes, learned restart capacity and APB registers.
//
// Behaviour
// RULE_01 - After overload trip, refuse reset until capacity reaches learned capacity-to-start; CTRL override bit or mode off clears it sooner.
// RULE_02 - Capacity-to-start is mean of capacity used in last three good starts; readable.
// RULE_03 - Reset attempt with insufficient recovery shows inhibited code instead of clearing.
// RULE_04 - All classes trip at 600 percent load; class N trips after N seconds.
// RULE_05 - After reset both start and run classes are class 10.
// RULE_06 - Use start class until at-speed, then the run class.
// RULE_07 - Start class accepts classes 5 through 20 only.
// RULE_08 - Run class accepts 5, 10, 15, 20, 25, 30 only.
// RULE_09 - With all three line phases absent, show the no-phase code.
// RULE_10 - Supervision stays active in bypass while the device drives the contactor.
// RULE_11 - Remaining capacity is a percentage, 100 when cool, dropping as motor heats.
// RULE_12 - Manual mode needs reset key after trip; held key never blocks a trip.
// RULE_13 - Overload lamp steady while tripped, flashing once reset is possible.
// RULE_14 - Capacity drops by current squared above threshold, scaled per class.
// RULE_15 - Learned average updates only when a start reaches speed without tripping.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
module motol_trip #(
	parameter int unsigned TICK_CYC = int'(motol_pkg::TICK_CYC),
	parameter int AW = 8
) (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [AW-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error, unmapped address
	input wire logic [11:0] current_pct, // Motor current, percent of full load
	input wire motol_pkg::motol_pins_t pins_i, // Asynchronous pins
	output logic trip_o, // Overload trip active
	output logic ol_led_o, // Overload lamp
	output motol_pkg::motol_disp_t disp_code_o, // Display code
	output logic irq_o // Interrupt, level
);
	// Synchronisers come up at the idle pin levels, so reset shows no false phase loss.
	localparam motol_pkg::motol_st_t RST = '{
		sync1: '{phase_ok: '1, default: '0},
		sync2: '{phase_ok: '1, default: '0},
		start_cls: motol_pkg::CLS_10,
		run_cls: motol_pkg::CLS_10,
		sf: motol_pkg::SF_RST,
		acc: motol_pkg::CAP_FULL,
		mode: motol_pkg::MODE_MANUAL,
		ol: motol_pkg::OL_CLEAR,
		disp: motol_pkg::DISP_NORMAL,
		default: '0
	};

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function automatic logic start_ok(input logic [4:0] c);
		return c == motol_pkg::CLS_5 || c == motol_pkg::CLS_10 ||
			c == motol_pkg::CLS_15 || c == motol_pkg::CLS_20;
	endfunction : start_ok

	function automatic logic run_ok(input logic [4:0] c);
		return start_ok(c) || c == motol_pkg::CLS_25 || c == motol_pkg::CLS_30;
	endfunction : run_ok

	// Weight is the common multiple divided by the class, so trip time scales with the class.
	function automatic logic [5:0] weight(input logic [4:0] c);
		return 6'(motol_pkg::CLASS_LCM / longint'(c));
	endfunction : weight

	// Divide by three as a multiply and shift; exact for every sum three percentages reach.
	function automatic logic [6:0] div3(input logic [2:0][6:0] h);
		logic [19:0] p;
		p = 20'({2'b00, h[0]} + {2'b00, h[1]} + {2'b00, h[2]}) * 20'(motol_pkg::DIV3_MUL);
		return p[motol_pkg::DIV3_SH +: 7];
	endfunction : div3

	motol_pkg::motol_st_t s;
	motol_pkg::motol_st_t n;
	logic wr;
	logic setup;
	logic tick;
	logic active;
	logic rst_req;
	logic learn;
	logic heat;
	logic [4:0] cls;
	logic [6:0] pct;
	logic [6:0] used_w;
	logic [motol_pkg::ACC_W-1:0] dec_w;

	// ------------------------------------------------------------
	// Shared terms
	// ------------------------------------------------------------
	assign wr = psel && penable && pwrite;
	assign setup = psel && !penable;
	// The tick sets the thermal time base; a shorter tick shortens every trip time alike.
	assign tick = s.tick_cnt == TICK_CYC - 1;
	// A contactor closed by outside control takes the motor out of our protection.
	assign active = s.mode != motol_pkg::MODE_OFF && !s.sync2.bypass_ext; // RULE_10
	assign cls = s.sync2.at_speed ? s.run_cls : s.start_cls; // RULE_06
	assign pct = s.acc[motol_pkg::FRAC_W +: 7]; // RULE_11
	assign heat = active && current_pct > s.sf;
	// Each factor is widened first; a product kept at operand width would lose its high bits.
	assign dec_w = motol_pkg::ACC_W'(current_pct) * motol_pkg::ACC_W'(current_pct) *
		motol_pkg::ACC_W'(weight(cls)); // RULE_14 RULE_04
	// The key counts on its rising edge only, so a held key asks for one reset.
	assign rst_req = (s.sync2.reset_key && !s.key_d) ||
		(wr && paddr == motol_pkg::OFF_CTRL && pwdata[motol_pkg::CTRL_RST_BIT]);
	assign learn = s.in_start && s.sync2.at_speed && !s.spd_d && s.ol == motol_pkg::OL_CLEAR;
	// Usage counts from the snapshot taken when the start began.
	assign used_w = s.start_pct > pct ? s.start_pct - pct : '0;

	assign prdata = s.prdata;
	// No wait states: read data is loaded in setup and writes land in the access phase.
	assign pready = 1'b1;
	assign pslverr = s.slverr;
	assign trip_o = s.ol[0];
	assign ol_led_o = s.led;
	assign disp_code_o = s.disp;
	assign irq_o = s.irq;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [motol_pkg::IRQ_W-1:0] ev;
		ev = '0;
		n = s;
		// Pins pass two flip-flops before any logic reads them.
		n.sync1 = pins_i;
		n.sync2 = s.sync1;
		n.key_d = s.sync2.reset_key;
		n.run_d = s.sync2.motor_run;
		n.spd_d = s.sync2.at_speed;
		n.noph_d = s.sync2.phase_ok == '0;
		if (wr) begin
			case (paddr)
				motol_pkg::OFF_CTRL: begin
					if (pwdata[1:0] != 2'b11) begin
						n.mode = motol_pkg::motol_mode_t'(pwdata[1:0]);
					end
					n.ovr = pwdata[motol_pkg::CTRL_OVR_BIT];
				end
				motol_pkg::OFF_START_CLS: begin
					if (start_ok(pwdata[4:0])) begin // RULE_07
						n.start_cls = pwdata[4:0];
					end
				end
				motol_pkg::OFF_RUN_CLS: begin
					if (run_ok(pwdata[4:0])) begin // RULE_08
						n.run_cls = pwdata[4:0];
					end
				end
				motol_pkg::OFF_SF: n.sf = pwdata[11:0];
				motol_pkg::OFF_IRQ_CLR: n.irq_st = s.irq_st & ~pwdata[motol_pkg::IRQ_W-1:0];
				motol_pkg::OFF_IRQ_EN: n.irq_en = pwdata[motol_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end

		// Thermal register advances once per tick; it never leaves 0..full.
		n.tick_cnt = tick ? '0 : s.tick_cnt + 32'h0000_0001;
		if (tick) begin
			n.flash = s.flash + 6'h01;
			if (heat) begin
				n.acc = s.acc > dec_w ? s.acc - dec_w : '0; // RULE_14
			end else if (s.acc > motol_pkg::CAP_FULL - motol_pkg::COOL_STEP) begin
				n.acc = motol_pkg::CAP_FULL; // RULE_11
			end else begin
				n.acc = s.acc + motol_pkg::COOL_STEP;
			end
		end

		// Start learning.
		if (s.sync2.motor_run && !s.run_d) begin
			n.in_start = 1'b1;
			n.start_pct = pct;
		end
		if (!s.sync2.motor_run) begin
			n.in_start = 1'b0;
		end
		if (learn) begin // RULE_15
			n.in_start = 1'b0;
			// Newest usage enters at index zero and the oldest falls out.
			n.hist = {s.hist[1:0], used_w};
			ev[motol_pkg::IRQ_LEARN] = 1'b1;
		end
		n.cts = div3(n.hist); // RULE_02

		// Trip sequencing.
		case (s.ol)
			motol_pkg::OL_CLEAR: begin
				// The key plays no part here, so a held key cannot mask a trip.
				if (active && s.acc == '0) begin // RULE_12
					n.ol = motol_pkg::OL_TRIP;
					n.in_start = 1'b0; // RULE_15
					ev[motol_pkg::IRQ_TRIP] = 1'b1;
				end
			end
			motol_pkg::OL_TRIP: begin
				// Switching supervision off releases a held trip; outside protection takes over.
				if (s.mode == motol_pkg::MODE_OFF) begin
					n.ol = motol_pkg::OL_CLEAR;
					n.inhibit = 1'b0;
				end else if (rst_req) begin
					if (pct >= s.cts || s.ovr) begin // RULE_01
						n.ol = motol_pkg::OL_CLEAR;
						n.inhibit = 1'b0;
					end else begin
						n.inhibit = 1'b1; // RULE_03
						ev[motol_pkg::IRQ_INH] = 1'b1;
					end
				end else if (pct >= s.cts) begin // RULE_01
					n.ol = motol_pkg::OL_READY;
					ev[motol_pkg::IRQ_READY] = 1'b1;
				end
			end
			motol_pkg::OL_READY: begin
				if (s.mode != motol_pkg::MODE_MANUAL || rst_req) begin // RULE_12
					n.ol = motol_pkg::OL_CLEAR;
					n.inhibit = 1'b0;
				end
			end
			default: n.ol = motol_pkg::OL_CLEAR;
		endcase

		if (s.sync2.phase_ok == '0 && !s.noph_d) begin
			ev[motol_pkg::IRQ_NOPH] = 1'b1;
		end
		if (s.sync2.phase_ok == '0) begin
			n.disp = motol_pkg::DISP_NO_3PH; // RULE_09
		end else if (n.inhibit) begin
			n.disp = motol_pkg::DISP_INHIBIT; // RULE_03
		end else begin
			n.disp = motol_pkg::DISP_NORMAL;
		end
		n.led = n.ol == motol_pkg::OL_TRIP ||
			(n.ol == motol_pkg::OL_READY && n.flash[motol_pkg::FLASH_BIT]); // RULE_13

		// An event in the cycle of its clear still sets the bit.
		n.irq_st = n.irq_st | ev;
		n.irq = |(n.irq_st & n.irq_en);

		// Read data and error are settled during the setup phase.
		if (setup) begin
			n.prdata = '0;
			n.slverr = 1'b0;
			case (paddr)
				motol_pkg::OFF_CTRL: n.prdata = {29'h0000_0000, s.ovr, s.mode};
				motol_pkg::OFF_START_CLS: n.prdata[4:0] = s.start_cls;
				motol_pkg::OFF_RUN_CLS: n.prdata[4:0] = s.run_cls;
				motol_pkg::OFF_SF: n.prdata[11:0] = s.sf;
				motol_pkg::OFF_STATUS: begin
					n.prdata[6:0] = pct;
					n.prdata[motol_pkg::ST_TRIP_BIT] = s.ol[0];
					n.prdata[motol_pkg::ST_READY_BIT] = s.ol == motol_pkg::OL_READY;
					n.prdata[motol_pkg::ST_INH_BIT] = s.inhibit;
					n.prdata[motol_pkg::ST_SPEED_BIT] = s.sync2.at_speed;
					n.prdata[motol_pkg::ST_START_BIT] = s.in_start;
					n.prdata[motol_pkg::ST_NOPH_BIT] = s.noph_d;
					n.prdata[motol_pkg::ST_ACTIVE_BIT] = active;
				end
				motol_pkg::OFF_CTS_VIEW: n.prdata[6:0] = s.cts; // RULE_02
				motol_pkg::OFF_IRQ_ST: n.prdata[motol_pkg::IRQ_W-1:0] = s.irq_st;
				motol_pkg::OFF_IRQ_CLR: ;
				motol_pkg::OFF_IRQ_EN: n.prdata[motol_pkg::IRQ_W-1:0] = s.irq_en;
				default: n.slverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= RST; // RULE_05
		end else begin
			s <= n;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// All checks run on the bus clock and rest while reset is held.
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	reset_gate_a: assert property (s.ol == motol_pkg::OL_TRIP && rst_req && pct < s.cts && !s.ovr
		&& s.mode != motol_pkg::MODE_OFF |=> s.ol == motol_pkg::OL_TRIP) // RULE_01
		else $error("Trip cleared before capacity recovered.");
	cts_mean_a: assert property (learn |=> s.hist[0] == $past(used_w) ##0
		s.cts == div3(s.hist)) // RULE_02
		else $error("Capacity-to-start not the mean of the last starts.");
	inhibit_show_a: assert property (s.ol == motol_pkg::OL_TRIP && rst_req && pct < s.cts
		&& !s.ovr && s.mode != motol_pkg::MODE_OFF && s.sync2.phase_ok != '0
		|=> disp_code_o == motol_pkg::DISP_INHIBIT) // RULE_03
		else $error("Refused reset not shown as inhibited.");
	class_ref_a: assert property (weight(cls) * cls == motol_pkg::CLASS_LCM) // RULE_04
		else $error("Class weight does not meet its reference time.");
	reset_class_a: assert property ($rose(presetn) |-> s.start_cls == motol_pkg::CLS_10
		&& s.run_cls == motol_pkg::CLS_10) // RULE_05
		else $error("Classes not at class 10 after reset.");
	class_use_a: assert property (tick && heat && s.acc > dec_w
		|=> s.acc == $past(s.acc) - $past(dec_w)) // RULE_06
		else $error("Thermal step does not match the selected class.");
	start_range_a: assert property (start_ok(s.start_cls)) // RULE_07
		else $error("Start class out of range.");
	run_range_a: assert property (run_ok(s.run_cls)) // RULE_08
		else $error("Run class not an accepted value.");
	no_phase_a: assert property (s.sync2.phase_ok == '0
		|=> disp_code_o == motol_pkg::DISP_NO_3PH) // RULE_09
		else $error("No-phase code not shown.");
	bypass_hold_a: assert property (s.sync2.bypass_ext && s.ol == motol_pkg::OL_CLEAR
		|=> s.ol == motol_pkg::OL_CLEAR) // RULE_10
		else $error("Trip while contactor under outside control.");
	cap_range_a: assert property (pct <= motol_pkg::PCT_FULL) // RULE_11
		else $error("Remaining capacity above full.");
	trip_free_a: assert property (s.ol == motol_pkg::OL_CLEAR && active && s.acc == '0
		|=> trip_o && ol_led_o) // RULE_12
		else $error("Exhausted capacity did not trip.");
	led_steady_a: assert property (s.ol == motol_pkg::OL_TRIP |-> ol_led_o) // RULE_13
		else $error("Lamp not steady while tripped.");
	learn_gate_a: assert property (!s.in_start |=> $stable(s.hist)) // RULE_15
		else $error("Average updated outside a good start.");
	trip_drop_a: assert property (s.ol == motol_pkg::OL_CLEAR && active && s.acc == '0
		|=> !s.in_start) // RULE_15
		else $error("Start still open after a trip.");
	led_flash_a: assert property (s.ol == motol_pkg::OL_READY
		|-> ol_led_o == s.flash[motol_pkg::FLASH_BIT]) // RULE_13
		else $error("Lamp not flashing once reset is possible.");
	noph_irq_a: assert property (s.sync2.phase_ok == '0 && !s.noph_d
		|=> s.irq_st[motol_pkg::IRQ_NOPH]) // RULE_09
		else $error("Phase loss not recorded as an event.");
	cool_up_a: assert property (tick && !heat |=> s.acc >= $past(s.acc)) // RULE_11
		else $error("Capacity fell without overload current.");
	auto_reset_a: assert property (s.ol == motol_pkg::OL_READY
		&& s.mode == motol_pkg::MODE_AUTO |=> s.ol == motol_pkg::OL_CLEAR) // RULE_12
		else $error("Automatic mode did not release the trip.");
	manual_hold_a: assert property (s.ol == motol_pkg::OL_READY
		&& s.mode == motol_pkg::MODE_MANUAL && !rst_req
		|=> s.ol == motol_pkg::OL_READY) // RULE_12
		else $error("Manual mode released the trip without a request.");

	trip_c: cover property (s.ol == motol_pkg::OL_CLEAR ##1 s.ol == motol_pkg::OL_TRIP);
	ready_c: cover property (s.ol == motol_pkg::OL_READY ##1 s.ol == motol_pkg::OL_CLEAR);
	learn_c: cover property (learn);
	inhibit_c: cover property (disp_code_o == motol_pkg::DISP_INHIBIT);
	noph_c: cover property (disp_code_o == motol_pkg::DISP_NO_3PH);
endmodule : motol_trip

/* pkg/motol_pkg.sv */
// Package for the motor overload trip block: register map, fields, types and constants.
package motol_pkg;
	// ------------------------------------------------------------
	// Register map (byte offsets)
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_START_CLS = 8'h04;
	localparam logic [7:0] OFF_RUN_CLS = 8'h08;
	localparam logic [7:0] OFF_SF = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_CTS_VIEW = 8'h14;
	localparam logic [7:0] OFF_IRQ_ST = 8'h18;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h1C;
	localparam logic [7:0] OFF_IRQ_EN = 8'h20;
	// ------------------------------------------------------------
	// Fields
	// ------------------------------------------------------------
	localparam int CTRL_OVR_BIT = 2;
	localparam int CTRL_RST_BIT = 3;
	localparam int ST_TRIP_BIT = 8;
	localparam int ST_READY_BIT = 9;
	localparam int ST_INH_BIT = 10;
	localparam int ST_SPEED_BIT = 11;
	localparam int ST_START_BIT = 12;
	localparam int ST_NOPH_BIT = 13;
	localparam int ST_ACTIVE_BIT = 14;
	localparam int IRQ_W = 5;
	localparam int IRQ_TRIP = 0;
	localparam int IRQ_READY = 1;
	localparam int IRQ_INH = 2;
	localparam int IRQ_NOPH = 3;
	localparam int IRQ_LEARN = 4;
	// ------------------------------------------------------------
	// Trip classes and thermal scaling
	// ------------------------------------------------------------
	localparam logic [4:0] CLS_5 = 5'h05;
	localparam logic [4:0] CLS_10 = 5'h0A;
	localparam logic [4:0] CLS_15 = 5'h0F;
	localparam logic [4:0] CLS_20 = 5'h14;
	localparam logic [4:0] CLS_25 = 5'h19;
	localparam logic [4:0] CLS_30 = 5'h1E;
	localparam logic [11:0] SF_RST = 12'h073;
	localparam int ACC_W = 43;
	localparam int FRAC_W = 36;
	localparam logic [ACC_W-1:0] CAP_FULL = 43'h640_0000_0000;
	localparam logic [ACC_W-1:0] COOL_STEP = 43'h000_4000_0000;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam longint unsigned CLK_HZ = 64'h0000_0000_0EE6_B280;
	localparam longint unsigned REF_PCT = 64'h0000_0000_0000_0258;
	localparam longint unsigned CLASS_LCM = 64'h0000_0000_0000_012C;
	localparam longint unsigned CLASS_UNIT_S = 64'h0000_0000_0000_0001;
	localparam longint unsigned TICK_CYC =
		CLK_HZ * CLASS_UNIT_S * REF_PCT * REF_PCT * CLASS_LCM / CAP_FULL;
	localparam int FLASH_BIT = 5;
	localparam logic [10:0] DIV3_MUL = 11'h2AB;
	localparam int DIV3_SH = 11;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {MODE_MANUAL = 2'h0, MODE_AUTO = 2'h1, MODE_OFF = 2'h2} motol_mode_t;
	typedef enum logic [1:0] {OL_CLEAR = 2'h0, OL_TRIP = 2'h1, OL_READY = 2'h3} motol_ol_t;
	typedef enum logic [1:0] {DISP_NORMAL = 2'h0, DISP_INHIBIT = 2'h1, DISP_NO_3PH = 2'h2} motol_disp_t;
	typedef struct packed {
		logic at_speed;
		logic motor_run;
		logic reset_key;
		logic bypass_ext;
		logic [2:0] phase_ok;
	} motol_pins_t;
	typedef struct packed {
		motol_pins_t sync1;
		motol_pins_t sync2;
		logic key_d;
		logic run_d;
		logic spd_d;
		logic noph_d;
		motol_mode_t mode;
		logic ovr;
		logic [4:0] start_cls;
		logic [4:0] run_cls;
		logic [11:0] sf;
		logic [IRQ_W-1:0] irq_st;
		logic [IRQ_W-1:0] irq_en;
		logic irq;
		logic [ACC_W-1:0] acc;
		logic [31:0] tick_cnt;
		logic [5:0] flash;
		logic in_start;
		logic [6:0] start_pct;
		logic [2:0][6:0] hist;
		logic [6:0] cts;
		motol_ol_t ol;
		logic inhibit;
		logic led;
		motol_disp_t disp;
		logic [31:0] prdata;
		logic slverr;
	} motol_st_t;
endpackage : motol_pkg

/* verification/motol_motor_model.sv */
// Model of the motor current sensor and the operator keypad beside the overload block.
`timescale 1ns/10ps
module motol_motor_model (
	input wire logic pclk, // Clock
	input wire logic [11:0] load_pct, // Current the load draws while running
	input wire logic run, // Motor running
	input wire logic spd, // Motor at speed
	input wire logic key, // Reset key held down
	input wire logic byp, // Bypass contactor driven from outside
	input wire logic [2:0] ph, // Line phases present
	output logic [11:0] current_pct = 12'h000, // Sensed current
	output motol_pkg::motol_pins_t pins_o = '0 // Pins toward the block
);
	// A stopped motor draws nothing, whatever load is set, so it heats only while running.
	always @(posedge pclk) begin
		current_pct <= run ? load_pct : 12'h000;
		pins_o <= '{at_speed: spd, motor_run: run, reset_key: key, bypass_ext: byp, phase_ok: ph};
	end
endmodule : motol_motor_model

/* verification/tb_top.sv */
// Self-checking bench for the motor overload trip block.
`timescale 1ns/10ps
module tb_top;
	// ----------------------------------------
	// Setup
	// ----------------------------------------
	// Four cycles a tick keeps a full-scale trip near 27000 cycles.
	localparam int unsigned TICK = 4;
	// Heat taken per tick at 4095 percent load on class 5.
	localparam longint unsigned HEAT = 64'h0000_0000_3BF8_803C;
	localparam longint unsigned NT = (motol_pkg::CAP_FULL + HEAT - 1) / HEAT;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [11:0] current_pct;
	motol_pkg::motol_pins_t pins;
	logic trip;
	logic led;
	motol_pkg::motol_disp_t disp;
	logic irq;
	logic [11:0] load;
	logic run, spd, key, byp;
	logic [2:0] ph;
	logic [31:0] q;
	logic err;
	logic [6:0] p0;
	int failures;
	int n_checks;
	int n;
	int used;

	motol_trip #(.TICK_CYC(TICK)) motol_trip_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.current_pct(current_pct), .pins_i(pins), .trip_o(trip), .ol_led_o(led),
		.disp_code_o(disp), .irq_o(irq)
	);
	motol_motor_model motol_motor_model_i (
		.pclk(pclk), .load_pct(load), .run(run), .spd(spd), .key(key), .byp(byp), .ph(ph),
		.current_pct(current_pct), .pins_o(pins)
	);

	always #2 pclk = ~pclk;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic ok(input logic c);
		chk({31'h0, c}, 32'h0000_0001);
	endtask : ok
	// Held until pready is seen high or 20 edges pass; released one idle edge before returning.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		logic seen;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		seen = (pready === 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
		if (!seen) begin
			failures++;
			$display("BAD %0t bus answer never came", $time);
			summarize();
		end
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic st(input int b, input logic e);
		apb(1'b0, motol_pkg::OFF_STATUS, 32'h0000_0000);
		chk({31'h0, q[b]}, {31'h0, e});
	endtask : st
	task automatic wait_trip(input logic v, input int lim);
		n = 0;
		while (trip !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (trip !== v) begin
			failures++;
			$display("BAD %0t trip level never came", $time);
			summarize();
		end
	endtask : wait_trip
	// Counts edges until the lamp changes, giving up at 300.
	task automatic led_watch;
		logic l0;
		l0 = led;
		n = 0;
		while (led === l0 && n < 300) begin
			@(posedge pclk);
			n++;
		end
	endtask : led_watch

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{run, spd, key, byp} = 4'h0;
		load = 12'h0FFF;
		ph = 3'h7;
		failures = 0;
		n_checks = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(motol_pkg::OFF_START_CLS, 32'h0000_000A);
		rd(motol_pkg::OFF_RUN_CLS, 32'h0000_000A);
		rd(motol_pkg::OFF_CTS_VIEW, 32'h0000_0000);
		wr(motol_pkg::OFF_STATUS, 32'hFFFF_FFFF);
		rd(motol_pkg::OFF_STATUS, 32'h0000_4064);
		rd(8'h24, 32'h0000_0000);
		ok(err === 1'b1);
		wr(motol_pkg::OFF_START_CLS, 32'h0000_0019);
		rd(motol_pkg::OFF_START_CLS, 32'h0000_000A);
		wr(motol_pkg::OFF_START_CLS, 32'h0000_0005);
		wr(motol_pkg::OFF_START_CLS, 32'h0000_0007);
		rd(motol_pkg::OFF_START_CLS, 32'h0000_0005);
		wr(motol_pkg::OFF_START_CLS, 32'h0000_0014);
		rd(motol_pkg::OFF_START_CLS, 32'h0000_0014);
		for (int c = 5; c <= 30; c += 5) begin
			wr(motol_pkg::OFF_RUN_CLS, c);
			rd(motol_pkg::OFF_RUN_CLS, c);
		end
		wr(motol_pkg::OFF_RUN_CLS, 32'h0000_000C);
		rd(motol_pkg::OFF_RUN_CLS, 32'h0000_001E);
		wr(motol_pkg::OFF_RUN_CLS, 32'h0000_0005);
		wr(motol_pkg::OFF_IRQ_EN, 32'h0000_001F);
		// Run class 5 at speed while the key is held; start class 20 would trip four times later.
		spd <= 1'b1;
		key <= 1'b1;
		repeat (4) @(posedge pclk);
		run <= 1'b1;
		wait_trip(1'b1, 40000);
		ok(n >= (NT - 1) * TICK && n <= (NT + 2) * TICK + 8);
		run <= 1'b0;
		spd <= 1'b0;
		repeat (100) @(posedge pclk);
		ok(trip === 1'b1 && irq === 1'b1);
		rd(motol_pkg::OFF_IRQ_ST, 32'h0000_0003);
		led_watch();
		ok(n < 300);
		wr(motol_pkg::OFF_IRQ_EN, 32'h0000_0000);
		repeat (2) @(posedge pclk);
		ok(irq === 1'b0);
		wr(motol_pkg::OFF_IRQ_CLR, 32'h0000_001F);
		rd(motol_pkg::OFF_IRQ_ST, 32'h0000_0000);
		wr(motol_pkg::OFF_IRQ_EN, 32'h0000_001F);
		key <= 1'b0;
		repeat (4) @(posedge pclk);
		key <= 1'b1;
		wait_trip(1'b0, 20);
		key <= 1'b0;
		// Cool to about 20 percent, then learn from three starts on start class 5.
		repeat (5120) @(posedge pclk);
		wr(motol_pkg::OFF_START_CLS, 32'h0000_0005);
		used = 0;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, motol_pkg::OFF_STATUS, 32'h0000_0000);
			p0 = q[6:0];
			run <= 1'b1;
			repeat (1400) @(posedge pclk);
			load <= 12'h000;
			spd <= 1'b1;
			repeat (6) @(posedge pclk);
			apb(1'b0, motol_pkg::OFF_STATUS, 32'h0000_0000);
			used += p0 - q[6:0];
			run <= 1'b0;
			spd <= 1'b0;
			load <= 12'h0FFF;
			repeat (4) @(posedge pclk);
		end
		apb(1'b0, motol_pkg::OFF_CTS_VIEW, 32'h0000_0000);
		p0 = q[6:0];
		ok(p0 + 1 >= used / 3 && p0 <= used / 3 + 1 && p0 > 0);
		// Trip again from low capacity; the reset must now be held off.
		run <= 1'b1;
		wait_trip(1'b1, 40000);
		run <= 1'b0;
		led_watch();
		chk(n, 300);
		st(motol_pkg::ST_READY_BIT, 1'b0);
		wr(motol_pkg::OFF_CTRL, 32'h0000_0008);
		repeat (3) @(posedge pclk);
		ok(trip === 1'b1 && disp === motol_pkg::DISP_INHIBIT);
		st(motol_pkg::ST_INH_BIT, 1'b1);
		n = 0;
		do begin
			apb(1'b0, motol_pkg::OFF_STATUS, 32'h0000_0000);
			n++;
		end while (q[motol_pkg::ST_READY_BIT] !== 1'b1 && n < 2000);
		ok(q[motol_pkg::ST_READY_BIT] === 1'b1);
		ok(q[6:0] >= p0 && q[6:0] <= p0 + 1);
		led_watch();
		ok(n < 300);
		wr(motol_pkg::OFF_CTRL, 32'h0000_0008);
		wait_trip(1'b0, 20);
		ok(disp === motol_pkg::DISP_NORMAL);
		ph <= 3'h0;
		repeat (5) @(posedge pclk);
		ok(disp === motol_pkg::DISP_NO_3PH && irq === 1'b1);
		st(motol_pkg::ST_NOPH_BIT, 1'b1);
		ph <= 3'h7;
		byp <= 1'b1;
		repeat (5) @(posedge pclk);
		st(motol_pkg::ST_ACTIVE_BIT, 1'b0);
		byp <= 1'b0;
		repeat (5) @(posedge pclk);
		st(motol_pkg::ST_ACTIVE_BIT, 1'b1);
		summarize();
	end
endmodule : tb_top
